// [rtl/fsc_seq_check.sv]
`timescale 1ns/1ps
`default_nettype none
module fsc_seq_check
  import fsc_pkg::*;
#(
  parameter logic [31:0] SEC_CYC = SEC_CYCLES
) (
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             tx_frame_i,
  input  wire fsc_frame_type    rx_frame_i,
  input  wire logic             unavail_i,
  input  wire logic             undo_i,
  input  wire logic [CNT_W-1:0] undo_cnt_i,
  input  wire logic             err_other_i,
  output logic [SEQ_W-1:0]      tx_seq_o,
  output logic [SEQ_W-1:0]      exp_seq_o,
  output logic                  synced_o,
  output logic                  seq_err_o,
  output logic                  sync_loss_o,
  output var  fsc_perf_type     perf_o
);

  fsc_state_type    state_q;
  logic [SEQ_W-1:0] tx_seq_q;
  logic [SEQ_W-1:0] exp_q;
  logic [SEQ_W-1:0] grp_q [GROUP_LEN];
  logic [SEQ_W-1:0] grp_w [GROUP_LEN];
  logic [IDX_W-1:0] idx_q;
  logic             seq_err_q;
  logic             sync_loss_q;
  logic             group_done;
  logic             tracking;
  logic [GROUP_LEN-1:0] match;
  logic             all_ok;
  logic             swap_ok;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [SEQ_W-1:0] exp_at(input logic [SEQ_W-1:0] base,
                                              input int unsigned      pos);
    exp_at = base + SEQ_W'(pos);
  endfunction

  // ****************************************************************
  // Transmit numbering
  // ****************************************************************
  // Number each generated frame
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_seq_q <= SEQ_RST;
    end else if (tx_frame_i) begin
      tx_seq_q <= tx_seq_q + 16'h0001;
    end
  end

  // ****************************************************************
  // Group collection
  // ****************************************************************
  // Collect four frames
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      idx_q <= IDX_RST;
    end else if (rx_frame_i.valid) begin
      idx_q <= idx_q + 2'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rx_frame_i.valid) begin
      grp_q[idx_q] <= rx_frame_i.seq;
    end
  end

  assign group_done = rx_frame_i.valid && (idx_q == IDX_LST);
  assign tracking   = (state_q == ST_TRACK);

  // ****************************************************************
  // Group judgement
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < GROUP_LEN; gi++) begin : g_pos
      if (gi == GROUP_LEN - 1) begin : g_last
        assign grp_w[gi] = rx_frame_i.seq;
      end else begin : g_held
        assign grp_w[gi] = grp_q[gi];
      end
      assign match[gi] = (grp_w[gi] == exp_at(exp_q, gi));
    end
  endgenerate

  assign all_ok = &match;

  always_comb begin
    swap_ok = 1'b0;
    for (int i = 0; i < GROUP_LEN - 1; i++) begin
      if ((grp_w[i] == exp_at(exp_q, i + 1)) && (grp_w[i+1] == exp_at(exp_q, i)) &&
          ((match | (4'b0011 << i)) == 4'b1111)) begin
        swap_ok = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      seq_err_q   <= 1'b0;
      sync_loss_q <= 1'b0;
    end else begin
      seq_err_q   <= group_done && tracking && !all_ok && swap_ok;
      sync_loss_q <= group_done && tracking && !all_ok && !swap_ok;
    end
  end

  // ****************************************************************
  // Expected value and alignment
  // ****************************************************************
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= ST_HUNT;
      exp_q   <= SEQ_RST;
    end else if (group_done) begin
      case (state_q)
        ST_HUNT: begin
          exp_q   <= grp_w[GROUP_LEN-1] + 16'h0001;
          state_q <= ST_TRACK;
        end
        ST_TRACK: begin
          if (all_ok || swap_ok) begin
            exp_q <= exp_at(exp_q, GROUP_LEN);
          end else begin
            exp_q <= grp_w[GROUP_LEN-1] + 16'h0001;
          end
        end
        default: begin
          state_q <= ST_HUNT;
        end
      endcase
    end
  end

  // ****************************************************************
  // Second counts
  // ****************************************************************
  fsc_sec_count #(
    .SEC_CYC (SEC_CYC)
  ) u_sec (
    .clk_i      (clk_i),
    .sys_rst_i  (sys_rst_i),
    .unavail_i  (unavail_i),
    .undo_i     (undo_i),
    .undo_cnt_i (undo_cnt_i),
    .err_i      (seq_err_q | sync_loss_q | err_other_i),
    .perf_o     (perf_o)
  );

  assign tx_seq_o    = tx_seq_q;
  assign exp_seq_o   = exp_q;
  assign synced_o    = state_q[1];
  assign seq_err_o   = seq_err_q;
  assign sync_loss_o = sync_loss_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_flag_excl: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    !(seq_err_q && sync_loss_q))
    else $error("both mismatch flags raised");

  chk_swap_err: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (group_done && tracking && !all_ok && swap_ok) |=> seq_err_q && !sync_loss_q)
    else $error("single swap not flagged as sequence error");

  chk_loss_class: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (group_done && tracking && !all_ok && !swap_ok) |=> sync_loss_q && !seq_err_q)
    else $error("mismatch not flagged as sync loss");

  chk_flag_group: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (seq_err_q || sync_loss_q) |-> $past(group_done) && $past(idx_q) == IDX_LST)
    else $error("flag raised outside a group end");

  chk_exp_advance: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (group_done && tracking && (all_ok || swap_ok)) |=> exp_q == SEQ_W'($past(exp_q) + 4))
    else $error("expected value did not advance by one group");

  chk_realign: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (group_done && tracking && !all_ok && !swap_ok)
      |=> exp_q == SEQ_W'($past(rx_frame_i.seq) + 1))
    else $error("no realignment after sync loss");

  chk_tx_number: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    tx_frame_i |=> tx_seq_q == SEQ_W'($past(tx_seq_q) + 1))
    else $error("transmit number did not step");

  chk_clean_quiet: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (group_done && all_ok) |=> !seq_err_q && !sync_loss_q)
    else $error("flag raised on a clean group");

  chk_delay_two: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (group_done && tracking && grp_w[0] == exp_at(exp_q, 1) && grp_w[1] == exp_at(exp_q, 2)
      && grp_w[2] == exp_q) |=> sync_loss_q)
    else $error("two-position delay not flagged as sync loss");

endmodule
`default_nettype wire

// [rtl/fsc_pkg.sv]
// Overview of operation
// - Available seconds equal total minus unavailable
// - Error-free seconds counted only inside available time
// - Generated frames carry a running sequence number
// - Next expected number is updated once per received group of four frames
// - Sequence judged per group of four frames
// - Mismatch flags error or sync loss, never both
// - Single adjacent swap flags a sequence error
// - Any other mismatch flags a sync loss
// - Frame delayed two positions is sync loss
// - Unavailable seconds may later be recounted downward
package fsc_pkg;

  // ****************************************************************
  // Widths and counts
  // ****************************************************************
  localparam int unsigned SEQ_W     = 16;
  localparam int unsigned CNT_W     = 32;
  localparam int unsigned GROUP_LEN = 4;
  localparam int unsigned IDX_W     = 2;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam logic [31:0] SEC_NS        = 32'h3B9A_CA00;
  localparam logic [31:0] CLK_PERIOD_NS = 32'h0000_0004;
  localparam logic [31:0] SEC_CYCLES    = SEC_NS / CLK_PERIOD_NS;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [SEQ_W-1:0] SEQ_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000;
  localparam logic [IDX_W-1:0] IDX_RST = 2'h0;
  localparam logic [IDX_W-1:0] IDX_LST = 2'h3;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic             valid;
    logic [SEQ_W-1:0] seq;
  } fsc_frame_type;

  typedef struct packed {
    logic [CNT_W-1:0] total;
    logic [CNT_W-1:0] unavail;
    logic [CNT_W-1:0] avail;
    logic [CNT_W-1:0] err_free;
  } fsc_perf_type;

  typedef enum logic [1:0] {
    ST_HUNT  = 2'b01,
    ST_TRACK = 2'b10
  } fsc_state_type;

endpackage

// [rtl/fsc_sec_count.sv]
`timescale 1ns/1ps
`default_nettype none
module fsc_sec_count
  import fsc_pkg::*;
#(
  parameter logic [31:0] SEC_CYC = SEC_CYCLES
) (
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             unavail_i,
  input  wire logic             undo_i,
  input  wire logic [CNT_W-1:0] undo_cnt_i,
  input  wire logic             err_i,
  output var  fsc_perf_type     perf_o
);

  logic [31:0]      tick_cnt_q;
  logic             tick;
  logic             err_seen_q;
  logic [CNT_W-1:0] total_d;
  logic [CNT_W-1:0] unavail_d;
  fsc_perf_type     perf_q;

  // ****************************************************************
  // Second tick
  // ****************************************************************
  assign tick = (tick_cnt_q == SEC_CYC - 32'h0000_0001);

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tick_cnt_q <= CNT_RST;
    end else if (tick) begin
      tick_cnt_q <= CNT_RST;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
    end
  end

  // Error seen in current second, new event wins over clear
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      err_seen_q <= 1'b0;
    end else if (tick) begin
      err_seen_q <= err_i;
    end else begin
      err_seen_q <= err_seen_q | err_i;
    end
  end

  // ****************************************************************
  // Counters
  // ****************************************************************
  always_comb begin
    total_d   = perf_q.total + (tick ? 32'h0000_0001 : CNT_RST);
    unavail_d = perf_q.unavail + ((tick && unavail_i) ? 32'h0000_0001 : CNT_RST);
    if (undo_i) begin
      unavail_d = (unavail_d > undo_cnt_i) ? unavail_d - undo_cnt_i : CNT_RST;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      perf_q <= '0;
    end else begin
      perf_q.total   <= total_d;
      perf_q.unavail <= unavail_d;
      perf_q.avail   <= total_d - unavail_d;
      if (tick && !unavail_i && !err_seen_q) begin
        perf_q.err_free <= perf_q.err_free + 32'h0000_0001;
      end
    end
  end

  assign perf_o = perf_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_avail_diff: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    perf_q.avail == perf_q.total - perf_q.unavail)
    else $error("available seconds differ from total minus unavailable");

  chk_efs_step: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (tick && !unavail_i && !err_seen_q) |=> perf_q.err_free == $past(perf_q.err_free) + 1)
    else $error("error-free second not counted");

  chk_efs_hold: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (!tick || unavail_i || err_seen_q) |=> $stable(perf_q.err_free))
    else $error("error-free count moved without a clean second");

  chk_undo_drop: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (undo_i && !tick && undo_cnt_i != 0 && perf_q.unavail != 0)
      |=> perf_q.unavail < $past(perf_q.unavail))
    else $error("recount did not lower unavailable seconds");

endmodule
`default_nettype wire

// [testbench/fsc_net_model.sv]
`timescale 1ns/1ps
`default_nettype none
module fsc_net_model
  import fsc_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             tx_frame_i,
  input  wire logic [SEQ_W-1:0] tx_seq_i,
  output var  fsc_frame_type    rx_frame_o
);
  logic [SEQ_W-1:0] q[$];

  initial rx_frame_o = '0;

  // ****************************************************************
  // Frames in flight
  // ****************************************************************
  // Number per frame
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q.delete();
    end else if (tx_frame_i) begin
      q.push_back(tx_seq_i);
    end
  end

  // Return four frames in commanded order
  task automatic send_group(input int p[4], input int npop);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      #1;
      rx_frame_o.valid = 1'b1;
      rx_frame_o.seq   = q[p[i]];
    end
    @(posedge clk_i);
    #1;
    rx_frame_o.valid = 1'b0;
    rx_frame_o.seq   = ~rx_frame_o.seq;
    repeat (npop) void'(q.pop_front());
  endtask
endmodule
`default_nettype wire

// [testbench/tb_frame_sequence_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_frame_sequence_checker
  import fsc_pkg::*;
;
  logic             clk = 1'b0;
  logic             rst;
  logic             tx;
  logic             unav;
  logic             undo;
  logic [CNT_W-1:0] undo_cnt;
  logic             err_o;
  fsc_frame_type    rx;
  logic [SEQ_W-1:0] tx_seq;
  logic [SEQ_W-1:0] exp_seq;
  logic             synced;
  logic             seq_err;
  logic             sync_loss;
  fsc_perf_type     perf;
  int               num_errors = 0;
  int               n_compared = 0;
  int               n_errf     = 0;
  int               n_lossf    = 0;
  int               cyc        = 0;

  always #2 clk = ~clk;

  fsc_seq_check #(.SEC_CYC(32'h0000_0010)) dut (
    .clk_i(clk), .sys_rst_i(rst), .tx_frame_i(tx), .rx_frame_i(rx),
    .unavail_i(unav), .undo_i(undo), .undo_cnt_i(undo_cnt), .err_other_i(err_o),
    .tx_seq_o(tx_seq), .exp_seq_o(exp_seq), .synced_o(synced),
    .seq_err_o(seq_err), .sync_loss_o(sync_loss), .perf_o(perf));

  fsc_net_model net (.clk_i(clk), .sys_rst_i(rst), .tx_frame_i(tx), .tx_seq_i(tx_seq),
    .rx_frame_o(rx));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic give_verdict;
    $display("errors=%0d compared=%0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (seq_err === 1'b1) n_errf++;
    if (sync_loss === 1'b1) n_lossf++;
    if (cyc == 3000) begin
      num_errors++;
      give_verdict;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic do_tx(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
      tx = 1'b1;
    end
    @(posedge clk);
    #1;
    tx = 1'b0;
  endtask

  task automatic grp(input int p[4], input int ntx, input int ne, input int nl, input int e);
    int e0;
    int l0;
    e0 = n_errf;
    l0 = n_lossf;
    do_tx(ntx);
    net.send_group(p, ntx);
    repeat (3) @(posedge clk);
    #1;
    chk(n_errf - e0, ne); // error count
    chk(n_lossf - l0, nl); // loss count
    chk(exp_seq, 16'(e)); // next expected
  endtask

  task automatic wait_sec;
    logic [31:0] t;
    t = perf.total;
    for (int i = 0; i < 40 && perf.total === t; i++) begin
      @(posedge clk);
      #1;
    end
    chk(perf.total, t + 1); // total tick
  endtask

  task automatic undo_pulse(input logic [31:0] n);
    undo_cnt = n;
    undo = 1'b1;
    @(posedge clk);
    #1;
    undo = 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_align;
    grp('{0, 1, 2, 3}, 4, 0, 0, 4); // first group aligns
    chk(synced, 1'b1); // aligned
    chk(tx_seq, 16'h0004); // running number
    grp('{0, 1, 2, 3}, 4, 0, 0, 8); // in order
  endtask

  task automatic t_swap;
    int p[4];
    for (int k = 0; k < 3; k++) begin
      p = '{0, 1, 2, 3};
      p[k] = k + 1;
      p[k+1] = k;
      grp(p, 4, 1, 0, 12 + 4 * k); // adjacent swap
    end
  endtask

  task automatic t_delay_two;
    grp('{1, 2, 0, 3}, 4, 0, 1, 24); // delayed two
  endtask

  task automatic t_drop;
    grp('{0, 1, 3, 4}, 5, 0, 1, 29); // lost frame
    grp('{0, 1, 2, 3}, 4, 0, 0, 33); // realigned
  endtask

  task automatic t_seconds;
    fsc_perf_type p0;
    wait_sec;
    wait_sec;
    p0 = perf;
    wait_sec;
    chk(perf.err_free, p0.err_free + 1); // clean second
    chk(perf.avail, perf.total - perf.unavail); // difference
    repeat (5) @(posedge clk);
    #1;
    err_o = 1'b1;
    @(posedge clk);
    #1;
    err_o = 1'b0;
    wait_sec;
    chk(perf.err_free, p0.err_free + 1); // errored second
    unav = 1'b1;
    wait_sec;
    wait_sec;
    unav = 1'b0;
    chk(perf.unavail, p0.unavail + 2); // unavailable count
    chk(perf.err_free, p0.err_free + 1); // outside available
    chk(perf.avail, perf.total - perf.unavail); // difference
    undo_pulse(32'h0000_0001);
    chk(perf.unavail, p0.unavail + 1); // recount
    chk(perf.avail, perf.total - perf.unavail); // difference
    undo_pulse(32'hFFFF_FFFF);
    chk(perf.unavail, 32'h0000_0000); // floor at zero
    chk(perf.err_free, p0.err_free + 1); // unchanged
  endtask

  initial begin
    rst = 1'b1;
    tx = 1'b0;
    unav = 1'b0;
    undo = 1'b0;
    undo_cnt = '0;
    err_o = 1'b0;
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    chk(synced, 1'b0); // hunting
    t_align;
    t_swap;
    t_delay_two;
    t_drop;
    t_seconds;
    give_verdict;
  end
endmodule
`default_nettype wire
